/* rtl/ulim_top.sv */
// two usb port limit supervisors, auxiliary output and valley limit
`timescale 1ns/1ps
module ulim_top
    import ulim_pkg::*;
#(
    // timer counts, nominal durations by default
    parameter int unsigned WINDOW_CYC = BOOST_WINDOW_CYC,
    parameter int unsigned REARM_CYC = BOOST_REARM_CYC,
    parameter int unsigned TIMEOUT_CYC = LIMIT_TIMEOUT_CYC,
    parameter int unsigned OFF_CYC = HICCUP_OFF_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // port status, asynchronous comparator levels
    input wire logic [1:0] port_uvlo_ok,
    input wire logic [1:0] over_primary,
    input wire logic [1:0] over_secondary,
    input wire logic [1:0] over_fast,
    input wire logic [1:0] switch_hot,
    input wire logic [1:0] switch_cooled,
    input wire logic [1:0] sink_rd_seen,
    // auxiliary output comparators
    input wire logic aux_limiting,
    input wire logic aux_hot,
    input wire logic aux_cooled,
    // limit pin strap and programmed primary in ma
    input wire logic limit_set_pin_gnd,
    input wire logic [11:0] resistor_primary_ma,
    // buck low side
    input wire logic cycle_end,
    input wire logic over_valley,
    // port results
    output logic [1:0] port_switch_on,
    output logic [1:0] port_soft_start,
    output logic [1:0] port_hiccup,
    output logic [1:0] secondary_sel,
    output logic [11:0] primary_current_limit,
    output logic [12:0] secondary_current_limit,
    // auxiliary and buck results
    output logic aux_switch_on,
    output logic aux_hiccup,
    output logic buck_enable,
    output logic low_side_on,
    output logic high_side_on
);
    localparam int NIN = 20;
    logic [NIN-1:0] s1_q, s2_q;
    wire [NIN-1:0] raw = {port_uvlo_ok, over_primary, over_secondary,
        over_fast, switch_hot, switch_cooled, sink_rd_seen, aux_limiting,
        aux_hot, aux_cooled, cycle_end, over_valley, limit_set_pin_gnd};
    // two flops against metastability; s1 feeds only s2
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end
    wire [1:0] uv_ok = s2_q[19:18];
    wire [1:0] ovp = s2_q[17:16];
    wire [1:0] ovs = s2_q[15:14];
    wire [1:0] ovf = s2_q[13:12];
    wire [1:0] hot = s2_q[11:10];
    wire [1:0] cool = s2_q[9:8];
    wire [1:0] rd = s2_q[7:6];
    wire aux_lim = s2_q[5];
    wire aux_h = s2_q[4];
    wire aux_c = s2_q[3];
    wire cyc_end = s2_q[2];
    wire ovv = s2_q[1];
    wire lim_gnd = s2_q[0];

    wire [11:0] prim = lim_gnd ? DEFAULT_PRIMARY_MA : resistor_primary_ma;
    wire [15:0] sec_full = 16'((prim * SEC_NUM) / SEC_DEN);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            primary_current_limit <= 12'h000;
            secondary_current_limit <= 13'h0000;
        end else begin
            primary_current_limit <= prim;
            // 1.6x of a 12 bit primary needs 13 bits
            secondary_current_limit <= sec_full[12:0];
        end
    end

    // boost window per port
    logic [1:0] boost_q, rearm_q, armed_q;
    logic [CNT_W-1:0] bcnt_q [2];
    logic [1:0] prot_on;
    for (genvar p = 0; p < 2; p++) begin : g_port
        // other port over primary forces this one primary
        wire force_prim = ovp[1-p];
        wire abort = boost_q[p] && (ovs[p] || force_prim);
        wire win_end = bcnt_q[p] >= CNT_W'(WINDOW_CYC - 1);
        wire rearm_end = bcnt_q[p] >= CNT_W'(REARM_CYC - 1);
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                boost_q[p] <= 1'b0;
                rearm_q[p] <= 1'b0;
                armed_q[p] <= 1'b0;
                bcnt_q[p] <= '0;
            end else if (!uv_ok[p]) begin
                boost_q[p] <= 1'b0;
                rearm_q[p] <= 1'b0;
                armed_q[p] <= 1'b0;
                bcnt_q[p] <= '0;
            end else if (!armed_q[p] && !force_prim) begin
                armed_q[p] <= 1'b1;
                boost_q[p] <= 1'b1;
                bcnt_q[p] <= '0;
            end else if (boost_q[p] && (win_end || abort)) begin
                boost_q[p] <= 1'b0;
                rearm_q[p] <= 1'b1;
                bcnt_q[p] <= '0;
            end else if (rearm_q[p] && rearm_end) begin
                rearm_q[p] <= 1'b0;
                armed_q[p] <= 1'b0;
                bcnt_q[p] <= '0;
            end else begin
                bcnt_q[p] <= bcnt_q[p] + 1'b1;
            end
        end
        // primary limiting only counts once window is closed
        wire limiting = ovp[p] && !boost_q[p];
        // each port owns its own instance
        ulim_prot #(.TIMEOUT_CYC(TIMEOUT_CYC),
            .OFF_CYC(OFF_CYC)) u_prot (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .enable(uv_ok[p]),
            .limiting(limiting),
            .fast_trip(ovf[p]),
            .hot(hot[p]),
            .cooled(cool[p]),
            .switch_on(prot_on[p]),
            .soft_start(port_soft_start[p]),
            .hiccup(port_hiccup[p])
        );
    end
    assign secondary_sel = boost_q;
    assign port_switch_on = prot_on;

    logic buck_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            buck_q <= 1'b0;
        end else begin
            buck_q <= |rd;
        end
    end
    assign buck_enable = buck_q;

    // auxiliary output uses same hiccup timing
    ulim_prot #(.TIMEOUT_CYC(TIMEOUT_CYC),
        .OFF_CYC(OFF_CYC)) u_aux (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .enable(buck_q),
        .limiting(aux_lim),
        .fast_trip(1'b0),
        .hot(aux_h),
        .cooled(aux_c),
        .switch_on(aux_switch_on),
        .soft_start(),
        .hiccup(aux_hiccup)
    );

    // low side held past cycle end while over valley
    logic ls_q, hold_q;
    logic [7:0] dt_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ls_q <= 1'b0;
            hold_q <= 1'b0;
            dt_q <= 8'h00;
        end else if (!buck_q) begin
            ls_q <= 1'b0;
            hold_q <= 1'b0;
            dt_q <= 8'h00;
        end else if (hold_q || (cyc_end && ovv)) begin
            ls_q <= ovv;
            hold_q <= ovv;
            dt_q <= ovv ? 8'h00 : 8'(DEAD_TIME_CYC);
        end else if (dt_q != 8'h00) begin
            dt_q <= dt_q - 8'h01;
        end else begin
            ls_q <= 1'b0;
        end
    end
    assign low_side_on = ls_q;
    assign high_side_on = buck_q && !ls_q && dt_q == 8'h00 && !hold_q;

    window_close_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        boost_q[1] && ovs[1] && uv_ok[1] |=> !boost_q[1])
        else $error("secondary kept after over secondary");
    interlock_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        boost_q[0] && ovp[1] && uv_ok[0] |=> !boost_q[0])
        else $error("interlock did not force primary");
    one_boost_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ovp[0] && ovp[1] |=> ##1 !(boost_q[0] && boost_q[1]))
        else $error("both ports on secondary");
    buck_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd == 2'b00 |=> !buck_enable && !aux_switch_on)
        else $error("buck active without sink");
    fast_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ovf[1] |-> !port_switch_on[1])
        else $error("switch on during fast trip");
    default_lim_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        lim_gnd |=> primary_current_limit == DEFAULT_PRIMARY_MA)
        else $error("default primary wrong");
    valley_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        buck_q && hold_q && ovv |=> low_side_on && !high_side_on)
        else $error("low side released above valley");
    boost_c: cover property (@(posedge clk_sys) boost_q[0] ##1 !boost_q[0]);
    hiccup_c: cover property (@(posedge clk_sys) port_hiccup[0]);
    valley_c: cover property (@(posedge clk_sys) hold_q ##1 !hold_q);
endmodule

/* rtl/ulim_pkg.sv */
// constants for the usb port current limit supervisor
package ulim_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned BOOST_WINDOW_US = 2000;
    localparam int unsigned BOOST_REARM_US = 16000;
    localparam int unsigned LIMIT_TIMEOUT_NS = 4100000;
    localparam int unsigned HICCUP_OFF_US = 524000;
    localparam int unsigned SOFT_START_NS = 1000;
    localparam int unsigned DEAD_TIME_NS = 20;
    localparam int unsigned BOOST_WINDOW_CYC = BOOST_WINDOW_US * CLK_MHZ;
    localparam int unsigned BOOST_REARM_CYC = BOOST_REARM_US * CLK_MHZ;
    localparam int unsigned LIMIT_TIMEOUT_CYC =
        LIMIT_TIMEOUT_NS / 1000 * CLK_MHZ + LIMIT_TIMEOUT_NS % 1000 / 5;
    localparam int unsigned HICCUP_OFF_CYC = HICCUP_OFF_US * CLK_MHZ;
    localparam int unsigned SOFT_START_CYC = SOFT_START_NS * CLK_MHZ / 1000;
    localparam int unsigned DEAD_TIME_CYC = DEAD_TIME_NS * CLK_MHZ / 1000;
    localparam int unsigned CNT_W = 27;
    // secondary is 16/10 of primary
    localparam int unsigned SEC_NUM = 16;
    localparam int unsigned SEC_DEN = 10;
    // primary limit in ma when limit pin grounded
    localparam logic [11:0] DEFAULT_PRIMARY_MA = 12'hdde;
    typedef enum logic [1:0] {
        ULIM_NORMAL = 2'b00,
        ULIM_LIMIT = 2'b01,
        ULIM_OFF = 2'b11,
        ULIM_RETRY = 2'b10
    } ulim_prot_t;
endpackage

/* rtl/ulim_prot.sv */
// one protected output: limit timeout, hiccup, fast and thermal off
`timescale 1ns/1ps
module ulim_prot
    import ulim_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = 820000,
    parameter int unsigned OFF_CYC = 104800000
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // conditions, already synchronised
    input wire logic enable,
    input wire logic limiting,
    input wire logic fast_trip,
    input wire logic hot,
    input wire logic cooled,
    // results
    output logic switch_on,
    output logic soft_start,
    output logic hiccup
);
    ulim_prot_t st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic therm_q, therm_d;
    logic [7:0] ss_q, ss_d;
    wire timeout = cnt_q >= CNT_W'(TIMEOUT_CYC);
    wire off_done = cnt_q >= CNT_W'(OFF_CYC);

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + 1'b1;
        therm_d = therm_q ? !cooled : (hot && limiting);
        ss_d = (ss_q != 8'h00) ? ss_q - 8'h01 : 8'h00;
        if (fast_trip) begin
            ss_d = 8'(SOFT_START_CYC);
        end
        unique case (st_q)
            ULIM_NORMAL: begin
                cnt_d = '0;
                if (limiting) begin
                    st_d = ULIM_LIMIT;
                end
            end
            ULIM_LIMIT: begin
                if (!limiting) begin
                    st_d = ULIM_NORMAL;
                end else if (timeout) begin
                    st_d = ULIM_OFF;
                    cnt_d = '0;
                end
            end
            ULIM_OFF: begin
                if (off_done) begin
                    st_d = ULIM_RETRY;
                    cnt_d = '0;
                end
            end
            ULIM_RETRY: begin
                if (!limiting && timeout) begin
                    st_d = ULIM_NORMAL;
                end else if (timeout) begin
                    st_d = ULIM_OFF;
                    cnt_d = '0;
                end
            end
        endcase
        if (!enable) begin
            st_d = ULIM_NORMAL;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ULIM_NORMAL;
            cnt_q <= '0;
            therm_q <= 1'b0;
            ss_q <= 8'h00;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            therm_q <= therm_d;
            ss_q <= ss_d;
        end
    end

    // fast trip gates switch combinationally, ahead of the loop
    assign switch_on = enable && !fast_trip && !therm_q && st_q != ULIM_OFF;
    assign soft_start = ss_q != 8'h00;
    assign hiccup = st_q == ULIM_OFF || st_q == ULIM_RETRY;

    hiccup_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_q == ULIM_OFF |-> !switch_on)
        else $error("switch on during hiccup off");
endmodule

/* verif/ulim_sink_model.sv */
// usb sink drawing current from one supervised port
`timescale 1ns/1ps
module ulim_sink_model (
    // port power from the supervisor
    input wire logic switch_on,
    // load: 0 light, 1 above primary, 2 above secondary, 3 short
    input wire logic [1:0] demand,
    // comparator levels seen by the supervisor
    output logic over_primary,
    output logic over_secondary,
    output logic over_fast
);
    // no current flows while the switch is open, so levels collapse
    assign over_primary = switch_on && demand != 2'h0;
    assign over_secondary = switch_on && demand[1];
    assign over_fast = switch_on && demand == 2'h3;
endmodule

/* verif/testbench.sv */
// self-checking bench for the port limit supervisor
`timescale 1ns/1ps
module testbench;
    import ulim_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] port_uvlo_ok = 2'h0, switch_hot = 2'h0;
    logic [1:0] switch_cooled = 2'h0, sink_rd_seen = 2'h0;
    logic [1:0] demand0 = 2'h0, demand1 = 2'h0;
    logic aux_limiting = 1'b0, aux_hot = 1'b0, aux_cooled = 1'b0;
    logic limit_set_pin_gnd = 1'b1;
    logic [11:0] resistor_primary_ma = 12'h6a6;
    logic cycle_end = 1'b0, over_valley = 1'b0;
    logic [1:0] over_primary, over_secondary, over_fast;
    logic [1:0] port_switch_on, port_soft_start, port_hiccup, secondary_sel;
    logic [11:0] primary_current_limit;
    logic [12:0] secondary_current_limit;
    logic aux_switch_on, aux_hiccup, buck_enable, low_side_on, high_side_on;
    int mismatches = 0, n_compared = 0, cycles = 0;

    always #2.5 clk_sys = ~clk_sys;

    // short counts so window, rearm and hiccup fit in the run
    ulim_top #(.WINDOW_CYC(200), .REARM_CYC(1200), .TIMEOUT_CYC(60),
        .OFF_CYC(120)) dut (.clk_sys, .rst_n, .port_uvlo_ok, .over_primary,
        .over_secondary, .over_fast, .switch_hot, .switch_cooled,
        .sink_rd_seen, .aux_limiting, .aux_hot, .aux_cooled,
        .limit_set_pin_gnd, .resistor_primary_ma, .cycle_end, .over_valley,
        .port_switch_on, .port_soft_start, .port_hiccup, .secondary_sel,
        .primary_current_limit, .secondary_current_limit, .aux_switch_on,
        .aux_hiccup, .buck_enable, .low_side_on, .high_side_on);
    ulim_sink_model sink0 (.switch_on(port_switch_on[0]), .demand(demand0),
        .over_primary(over_primary[0]), .over_secondary(over_secondary[0]),
        .over_fast(over_fast[0]));
    ulim_sink_model sink1 (.switch_on(port_switch_on[1]), .demand(demand1),
        .over_primary(over_primary[1]), .over_secondary(over_secondary[1]),
        .over_fast(over_fast[1]));

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic t_limits();
        check("primary", primary_current_limit, 12'hdde);
        check("secondary", secondary_current_limit, 13'h1630);
        limit_set_pin_gnd <= 1'b0;
        step(5);
        check("primary prog", primary_current_limit, 12'h6a6);
        check("secondary prog", secondary_current_limit, 13'haa3);
    endtask

    task automatic t_boost();
        port_uvlo_ok <= 2'h3;
        step(5);
        check("boost open", secondary_sel, 2'h3);
        demand1 <= 2'h1;
        step(5);
        check("interlock", secondary_sel, 2'h2);
        check("full current", port_switch_on, 2'h3);
        demand1 <= 2'h2;
        step(5);
        check("over secondary", secondary_sel, 2'h0);
        check("no fast off", port_switch_on, 2'h3);
        demand1 <= 2'h0;
        step(1000);
        // rearm count of 1200 has not yet run out
        check("no rearm", secondary_sel, 2'h0);
        step(300);
        check("rearm", secondary_sel, 2'h3);
    endtask

    task automatic t_thermal();
        demand0 <= 2'h1;
        step(5);
        // port 0 still inside its rearmed window
        check("window pass", port_switch_on[0], 1'b1);
        check("interlock other", secondary_sel, 2'h1);
        step(100);
        check("window expiry", secondary_sel, 2'h0);
        switch_hot <= 2'h1;
        step(5);
        check("hot off", port_switch_on[0], 1'b0);
        check("other port", port_switch_on[1], 1'b1);
        switch_hot <= 2'h0;
        step(20);
        check("still off", port_switch_on[0], 1'b0);
        switch_cooled <= 2'h1;
        step(5);
        check("cooled on", port_switch_on[0], 1'b1);
        switch_cooled <= 2'h0;
        demand0 <= 2'h0;
    endtask

    task automatic t_fast();
        logic went_off;
        logic ramped;
        went_off = 1'b0;
        ramped = 1'b0;
        demand1 <= 2'h3;
        repeat (6) begin
            @(negedge clk_sys);
            went_off |= !port_switch_on[1];
        end
        @(posedge clk_sys);
        demand1 <= 2'h0;
        repeat (400) begin
            @(negedge clk_sys);
            ramped |= port_soft_start[1];
        end
        check("fast off", went_off, 1'b1);
        check("soft start", ramped, 1'b1);
        check("restart", port_switch_on[1], 1'b1);
        @(posedge clk_sys);
    endtask

    task automatic t_hiccup();
        demand0 <= 2'h1;
        aux_limiting <= 1'b1;
        step(70);
        check("hiccup", port_hiccup[0], 1'b1);
        check("hiccup off", port_switch_on[0], 1'b0);
        check("aux hiccup", aux_hiccup, 1'b1);
        check("aux off", aux_switch_on, 1'b0);
        check("other hiccup", port_hiccup[1], 1'b0);
        check("other on", port_switch_on[1], 1'b1);
        step(200);
        // retry still limiting, so off again
        check("hiccup again", port_hiccup[0], 1'b1);
        check("off again", port_switch_on[0], 1'b0);
        check("aux again", aux_hiccup, 1'b1);
        demand0 <= 2'h0;
        aux_limiting <= 1'b0;
        step(200);
        check("clean retry", port_hiccup[0], 1'b0);
        check("resumed", port_switch_on[0], 1'b1);
        check("aux clean", aux_hiccup, 1'b0);
        check("aux resumed", aux_switch_on, 1'b1);
    endtask

    task automatic t_buck();
        check("buck idle", buck_enable, 1'b0);
        sink_rd_seen <= 2'h1;
        step(5);
        check("buck on", buck_enable, 1'b1);
        cycle_end <= 1'b1;
        over_valley <= 1'b1;
        step(5);
        check("low held", {low_side_on, high_side_on}, 2'h2);
        over_valley <= 1'b0;
        step(12);
        check("low released", low_side_on, 1'b0);
        check("high after dead", high_side_on, 1'b1);
        aux_limiting <= 1'b1;
        aux_hot <= 1'b1;
        step(5);
        check("aux hot off", aux_switch_on, 1'b0);
        aux_hot <= 1'b0;
        aux_cooled <= 1'b1;
        step(5);
        check("aux cooled", aux_switch_on, 1'b1);
        aux_limiting <= 1'b0;
    endtask

    // a hang counts as a mismatch
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end

    initial begin
        step(8);
        check("reset outputs", {port_switch_on, secondary_sel}, 4'h0);
        rst_n <= 1'b1;
        step(5);
        t_limits();
        t_buck();
        t_boost();
        t_thermal();
        t_fast();
        t_hiccup();
        summarize();
    end
endmodule
